/* feature_id_pkg.sv */
package feature_id_pkg;

  // ==========================================================
  // Register map
  // ==========================================================
  localparam int unsigned      ADDR_W           = 12;
  localparam logic [11:0]      FEAT_WORD_OFFSET = 12'h000;
  localparam logic [11:0]      SEC_CTRL_OFFSET  = 12'h004;
  localparam logic [11:0]      CHECK_OFFSET     = 12'h008;
  localparam logic [31:0]      WORD_RESET       = 32'h0000_0000;
  localparam logic             NSSD_RESET       = 1'b0;

  // ==========================================================
  // Field positions of the feature word and of the secure control register
  // ==========================================================
  localparam int unsigned PROT_EXT_BIT   = 30;
  localparam int unsigned STREAM_TABLE_LEVELS_LSB   = 27;
  localparam int unsigned TERM_MODEL_BIT = 26;
  localparam int unsigned STALL_LSB      = 24;
  localparam int unsigned EXTRA_REC_BIT  = 23;
  localparam int unsigned ENDIAN_LSB     = 21;
  localparam int unsigned VXOP_BIT       = 20;
  localparam int unsigned TWO_LEVEL_CONTEXT_TABLE_BIT       = 19;
  localparam int unsigned WIDE_VMID_BIT  = 18;
  localparam int unsigned VMW_BIT        = 17;
  localparam int unsigned NSSD_BIT       = 0;

  // ==========================================================
  // Field encodings
  // ==========================================================
  localparam logic [1:0] ST_LINEAR      = 2'h0;
  localparam logic [1:0] ST_TWO_LEVEL   = 2'h1;
  localparam logic [1:0] STALL_BOTH     = 2'h0;
  localparam logic [1:0] STALL_NONE     = 2'h1;
  localparam logic [1:0] STALL_FORCED   = 2'h2;
  localparam logic [1:0] STALL_RSVD     = 2'h3;
  localparam logic [1:0] ENDIAN_MIXED   = 2'h0;
  localparam logic [1:0] ENDIAN_RSVD    = 2'h1;
  localparam logic [1:0] ENDIAN_LITTLE  = 2'h2;
  localparam logic [1:0] ENDIAN_BIG     = 2'h3;

  localparam logic [1:0] RESP_OKAY      = 2'h0;
  localparam logic [1:0] RESP_SLVERR    = 2'h2;

  typedef enum logic [1:0] {
    WR_IDLE = 2'b01,
    WR_RESP = 2'b10
  } wr_state_t;

  typedef enum logic [1:0] {
    RD_IDLE = 2'b01,
    RD_DATA = 2'b10
  } rd_state_t;

endpackage

/* feature_fields_if.sv */
`timescale 1ns/10ps
interface feature_fields_if;
  import feature_id_pkg::*;
  logic       prot_ext_supported;
  logic [1:0] stream_table_levels;
  logic       term_model;
  logic [1:0] own_stall_model;
  logic [1:0] secure_stall_model;
  logic       secure_state_present;
  logic       nonsecure_stall_disable;
  logic       extra_xlate_error_recording;
  logic [1:0] walk_endianness;
  logic       virtual_xlate_op_page;
  logic       two_level_context_table;
  logic       wide_vm_id;
  logic       vm_id_wildcard_inval;
  logic [31:0] word;
  logic [1:0] stall_model;

  modport owner (output prot_ext_supported, stream_table_levels, term_model,
                 own_stall_model, secure_stall_model, secure_state_present,
                 nonsecure_stall_disable, extra_xlate_error_recording,
                 walk_endianness, virtual_xlate_op_page, two_level_context_table,
                 wide_vm_id, vm_id_wildcard_inval, input word, stall_model);
  modport packer (input prot_ext_supported, stream_table_levels, term_model,
                  own_stall_model, secure_stall_model, secure_state_present,
                  nonsecure_stall_disable, extra_xlate_error_recording,
                  walk_endianness, virtual_xlate_op_page, two_level_context_table,
                  wide_vm_id, vm_id_wildcard_inval, output word, stall_model);
endinterface

/* feature_word_pack.sv */
`timescale 1ns/10ps
module feature_word_pack
  import feature_id_pkg::*;
(
  feature_fields_if.packer f  // Sanitised fields in, packed word out
);

  logic [1:0] stall_eff;

  // ==========================================================
  // Stall model seen by the non-secure side
  // ==========================================================
  always_comb begin
    stall_eff = f.own_stall_model;
    if (f.secure_state_present) begin
      if (f.secure_stall_model == STALL_BOTH && f.nonsecure_stall_disable) begin
        stall_eff = STALL_NONE;
      end else begin
        stall_eff = f.secure_stall_model;
      end
    end
  end

  assign f.stall_model = stall_eff;

  // ==========================================================
  // Word layout
  // ==========================================================
  always_comb begin
    f.word = WORD_RESET;
    f.word[PROT_EXT_BIT] = f.prot_ext_supported;
    f.word[STREAM_TABLE_LEVELS_LSB +: 2] = f.stream_table_levels;
    f.word[TERM_MODEL_BIT] = f.term_model;
    f.word[STALL_LSB +: 2] = stall_eff;
    f.word[EXTRA_REC_BIT] = f.extra_xlate_error_recording;
    f.word[ENDIAN_LSB +: 2] = f.walk_endianness;
    f.word[VXOP_BIT] = f.virtual_xlate_op_page;
    f.word[TWO_LEVEL_CONTEXT_TABLE_BIT] = f.two_level_context_table;
    f.word[WIDE_VMID_BIT] = f.wide_vm_id;
    f.word[VMW_BIT] = f.vm_id_wildcard_inval;
  end

endmodule

/* feature_id_regs.sv */
// The AXI4-Lite register port and the placing of the registers were decided locally.
`timescale 1ns/10ps
module feature_id_regs
  import feature_id_pkg::*;
#(
  parameter bit       PROT_EXT_IMPL    = 1'b0,
  parameter bit [1:0] STREAM_TABLE_LEVELS_IMPL    = 2'h1,
  parameter bit       TERM_MODEL_IMPL  = 1'b0,
  parameter bit [1:0] STALL_IMPL       = 2'h0,
  parameter bit       SECURE_STATE_PRESENT      = 1'b0,
  parameter bit [1:0] SEC_STALL_IMPL   = 2'h0,
  parameter bit       PCI_SYSTEM       = 1'b0,
  parameter bit       ATS_IMPL         = 1'b0,
  parameter bit       EXTRA_REC_IMPL   = 1'b0,
  parameter bit [1:0] ENDIAN_IMPL      = 2'h0,
  parameter bit       ADDRESS_XLATE_OPERATIONS_IMPL        = 1'b0,
  parameter bit       STAGE1_IMPL      = 1'b1,
  parameter bit       STAGE2_IMPL      = 1'b1,
  parameter bit       VXOP_IMPL        = 1'b0,
  parameter bit       TWO_LEVEL_CONTEXT_TABLE_IMPL        = 1'b1,
  parameter bit       WIDE_VM_ID_IMPL      = 1'b1,
  parameter bit       VMW_IMPL         = 1'b1
)(
  input  wire logic        aclk,             // Register clock, 125 MHz
  input  wire logic        aresetn,          // Synchronous reset, active low
  input  wire logic [11:0] s_axi_awaddr,     // Write address
  input  wire logic        s_axi_awvalid,    // Write address valid
  output logic             s_axi_awready,    // Write address ready
  input  wire logic [31:0] s_axi_wdata,      // Write data
  input  wire logic [3:0]  s_axi_wstrb,      // Write byte strobes
  input  wire logic        s_axi_wvalid,     // Write data valid
  output logic             s_axi_wready,     // Write data ready
  output logic [1:0]       s_axi_bresp,      // Write response
  output logic             s_axi_bvalid,     // Write response valid
  input  wire logic        s_axi_bready,     // Write response ready
  input  wire logic [11:0] s_axi_araddr,     // Read address
  input  wire logic        s_axi_arvalid,    // Read address valid
  output logic             s_axi_arready,    // Read address ready
  output logic [31:0]      s_axi_rdata,      // Read data
  output logic [1:0]       s_axi_rresp,      // Read response
  output logic             s_axi_rvalid,     // Read data valid
  input  wire logic        s_axi_rready,     // Read data ready
  output logic [31:0]      feature_word,     // Feature word for the unit
  output logic             protect_fault_ok, // Fault records may carry flag
  output logic             vm_id_hi_used,    // Upper VMID bits are honoured
  output logic             stall_allowed     // Non-secure stall usable
);

  // ==========================================================
  // Implementation values after sanitising
  // ==========================================================
  // Reserved or contradictory implementation choices are folded onto a
  // legal encoding so that software never sees a value it must reject.
  logic [1:0] stream_table_levels_ok;
  logic [1:0] endian_ok;
  logic [1:0] own_stall_ok;
  logic [1:0] sec_stall_ok;
  logic       vxop_ok;
  logic       extra_rec_ok;
  logic       vmw_ok;
  logic [7:0] check_flags;

  assign stream_table_levels_ok = STREAM_TABLE_LEVELS_IMPL[1] ? ST_LINEAR : STREAM_TABLE_LEVELS_IMPL;

  assign endian_ok = (ENDIAN_IMPL == ENDIAN_RSVD) ? ENDIAN_MIXED : ENDIAN_IMPL;

  function automatic logic [1:0] legal_stall(input logic [1:0] m);
    logic [1:0] r;
    r = m;
    if (m == STALL_RSVD) begin
      r = STALL_NONE;
    end
    if (m == STALL_FORCED && PCI_SYSTEM) begin
      r = STALL_NONE;
    end
    return r;
  endfunction

  assign own_stall_ok = legal_stall(STALL_IMPL);
  assign sec_stall_ok = legal_stall(SEC_STALL_IMPL);

  assign vxop_ok = VXOP_IMPL & ADDRESS_XLATE_OPERATIONS_IMPL & STAGE1_IMPL & STAGE2_IMPL;

  assign extra_rec_ok = EXTRA_REC_IMPL & ATS_IMPL;

  assign vmw_ok = VMW_IMPL & STAGE2_IMPL;

  assign check_flags = {
    1'b0,
    SECURE_STATE_PRESENT,
    (VMW_IMPL != vmw_ok),
    (EXTRA_REC_IMPL != extra_rec_ok),
    (VXOP_IMPL != vxop_ok),
    (STALL_IMPL != own_stall_ok) || (SEC_STALL_IMPL != sec_stall_ok),
    (ENDIAN_IMPL != endian_ok),
    (STREAM_TABLE_LEVELS_IMPL != stream_table_levels_ok)
  };

  // ==========================================================
  // State
  // ==========================================================
  typedef struct packed {
    wr_state_t   wr;
    rd_state_t   rd;
    logic        aw_got;
    logic        w_got;
    logic [11:0] awaddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        nssd;
    logic [31:0] word;
    logic [1:0]  stall;
  } state_t;

  state_t st;
  state_t next_st;

  // ==========================================================
  // Word composition
  // ==========================================================
  feature_fields_if fields ();

  assign fields.prot_ext_supported          = PROT_EXT_IMPL;
  assign fields.stream_table_levels         = stream_table_levels_ok;
  assign fields.term_model                  = TERM_MODEL_IMPL;
  assign fields.own_stall_model             = own_stall_ok;
  assign fields.secure_stall_model          = sec_stall_ok;
  assign fields.secure_state_present        = SECURE_STATE_PRESENT;
  assign fields.nonsecure_stall_disable     = st.nssd;
  assign fields.extra_xlate_error_recording = extra_rec_ok;
  assign fields.walk_endianness             = endian_ok;
  assign fields.virtual_xlate_op_page       = vxop_ok;
  assign fields.two_level_context_table     = TWO_LEVEL_CONTEXT_TABLE_IMPL;
  assign fields.wide_vm_id                  = WIDE_VM_ID_IMPL;
  assign fields.vm_id_wildcard_inval        = vmw_ok;

  feature_word_pack i_feature_word_pack (
    .f (fields.packer)
  );

  // ==========================================================
  // Read decode
  // ==========================================================
  function automatic logic [31:0] read_word(input logic [11:0] a, input state_t s);
    logic [31:0] d;
    d = WORD_RESET;
    unique case (a)
      FEAT_WORD_OFFSET: d = s.word;
      SEC_CTRL_OFFSET:  d[NSSD_BIT] = s.nssd;
      CHECK_OFFSET:     d = {22'h00_0000, s.stall, check_flags};
      default:          d = WORD_RESET;
    endcase
    return d;
  endfunction

  function automatic logic mapped(input logic [11:0] a);
    return (a == FEAT_WORD_OFFSET) || (a == SEC_CTRL_OFFSET) ||
           (a == CHECK_OFFSET);
  endfunction

  // ==========================================================
  // Next state
  // ==========================================================
  always_comb begin
    next_st = st;

    // The word is re-registered every cycle, so a change of the
    // stall-disable control is visible one edge after its write.
    next_st.word  = fields.word;
    next_st.stall = fields.stall_model;

    // Write channel.
    unique case (st.wr)
      WR_IDLE: begin
        if (s_axi_awvalid && !st.aw_got) begin
          next_st.aw_got = 1'b1;
          next_st.awaddr = {s_axi_awaddr[11:2], 2'b00};
        end
        if (s_axi_wvalid && !st.w_got) begin
          next_st.w_got = 1'b1;
          next_st.wdata = s_axi_wdata;
          next_st.wstrb = s_axi_wstrb;
        end
        if (next_st.aw_got && next_st.w_got) begin
          next_st.aw_got = 1'b0;
          next_st.w_got  = 1'b0;
          next_st.wr     = WR_RESP;
          next_st.bresp  = mapped(next_st.awaddr) ? RESP_OKAY : RESP_SLVERR;
          if (next_st.awaddr == SEC_CTRL_OFFSET && next_st.wstrb[0]) begin
            next_st.nssd = next_st.wdata[NSSD_BIT];
          end
        end
      end
      WR_RESP: begin
        if (s_axi_bready) begin
          next_st.wr = WR_IDLE;
        end
      end
    endcase

    // Read channel.
    unique case (st.rd)
      RD_IDLE: begin
        if (s_axi_arvalid) begin
          next_st.rd    = RD_DATA;
          next_st.rdata = read_word({s_axi_araddr[11:2], 2'b00}, st);
          next_st.rresp = mapped({s_axi_araddr[11:2], 2'b00}) ? RESP_OKAY : RESP_SLVERR;
        end
      end
      RD_DATA: begin
        if (s_axi_rready) begin
          next_st.rd = RD_IDLE;
        end
      end
    endcase

    if (!aresetn) begin
      next_st.wr     = WR_IDLE;
      next_st.rd     = RD_IDLE;
      next_st.aw_got = 1'b0;
      next_st.w_got  = 1'b0;
      next_st.awaddr = FEAT_WORD_OFFSET;
      next_st.wdata  = WORD_RESET;
      next_st.wstrb  = 4'h0;
      next_st.bresp  = RESP_OKAY;
      next_st.rdata  = WORD_RESET;
      next_st.rresp  = RESP_OKAY;
      next_st.nssd   = NSSD_RESET;
      next_st.word   = WORD_RESET;
      next_st.stall  = STALL_BOTH;
    end
  end

  always_ff @(posedge aclk) begin
    st <= next_st;
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  assign s_axi_awready = (st.wr == WR_IDLE) && !st.aw_got;
  assign s_axi_wready  = (st.wr == WR_IDLE) && !st.w_got;
  assign s_axi_bvalid  = (st.wr == WR_RESP);
  assign s_axi_bresp   = st.bresp;
  assign s_axi_arready = (st.rd == RD_IDLE);
  assign s_axi_rvalid  = (st.rd == RD_DATA);
  assign s_axi_rdata   = st.rdata;
  assign s_axi_rresp   = st.rresp;

  assign feature_word     = st.word;
  assign protect_fault_ok = st.word[PROT_EXT_BIT];
  assign vm_id_hi_used    = st.word[WIDE_VMID_BIT];
  assign stall_allowed    = (st.stall != STALL_NONE);

endmodule

/* feature_id_regs_properties.sv */
`timescale 1ns/10ps
module feature_id_regs_properties
  import feature_id_pkg::*;
(
  input wire logic        aclk,             // Clock
  input wire logic        aresetn,          // Reset, active low
  input wire logic [11:0] s_axi_araddr,     // Read address
  input wire logic        s_axi_arvalid,    // Read address valid
  input wire logic        s_axi_arready,    // Read address ready
  input wire logic [31:0] s_axi_rdata,      // Read data
  input wire logic        s_axi_rvalid,     // Read data valid
  input wire logic        s_axi_rready,     // Read data ready
  input wire logic [31:0] feature_word,     // Feature word
  input wire logic        protect_fault_ok, // Protect flag allowed
  input wire logic        vm_id_hi_used,    // Wide VMID honoured
  input wire logic        stall_allowed     // Stall usable
);
  // ========================================
  // Sequences and properties
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_ar_word;
    s_axi_arvalid && s_axi_arready && s_axi_araddr[11:2] == 10'h000;
  endsequence
  sequence s_rd_held;
    s_axi_rvalid && !s_axi_rready;
  endsequence

  property p_rsvd_zero;
    feature_word[31] == 1'h0 && feature_word[29] == 1'h0;
  endproperty
  a_rsvd_zero:
    assert property (p_rsvd_zero) else $error("Reserved feature bit set");
  property p_stream_table_levels;
    feature_word[28] == 1'h0;
  endproperty
  a_stream_table_levels:
    assert property (p_stream_table_levels) else $error("Reserved stream table code");
  property p_stall_code;
    feature_word[25:24] != STALL_RSVD;
  endproperty
  a_stall_code:
    assert property (p_stall_code) else $error("Reserved stall code");
  property p_endian_code;
    feature_word[22:21] != ENDIAN_RSVD;
  endproperty
  a_endian_code:
    assert property (p_endian_code) else $error("Reserved endian code");
  property p_protect_out;
    protect_fault_ok == feature_word[30];
  endproperty
  a_protect_out:
    assert property (p_protect_out) else $error("Protect flag output wrong");
  property p_vmid_out;
    vm_id_hi_used == feature_word[18];
  endproperty
  a_vmid_out:
    assert property (p_vmid_out) else $error("Wide VMID output wrong");
  property p_stall_out;
    stall_allowed == (feature_word[25:24] != STALL_NONE);
  endproperty
  a_stall_out:
    assert property (p_stall_out) else $error("Stall output wrong");
  // The word is loaded at the first edge after reset, so two clean edges are needed.
  property p_word_fixed;
    $past(aresetn) && $past(aresetn, 2) |->
      $stable({feature_word[31:26], feature_word[23:0]});
  endproperty
  a_word_fixed:
    assert property (p_word_fixed) else $error("Fixed field changed");
  property p_word_read;
    s_ar_word |=> s_axi_rdata == $past(feature_word);
  endproperty
  a_word_read:
    assert property (p_word_read) else $error("Read data differs from word");
  property p_rd_held;
    s_rd_held |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rd_held:
    assert property (p_rd_held) else $error("Read data dropped");
endmodule

bind feature_id_regs feature_id_regs_properties i_feature_id_regs_properties (
  .aclk(aclk), .aresetn(aresetn), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .feature_word(feature_word), .protect_fault_ok(protect_fault_ok),
  .vm_id_hi_used(vm_id_hi_used), .stall_allowed(stall_allowed));

/* iommu_feature_id_register0_tb.sv */
`timescale 1ns/10ps
module iommu_feature_id_register0_tb;
  import feature_id_pkg::*;
  localparam logic [31:0] HI_MASK  = 32'hFFFE_0000;
  localparam logic [31:0] EXP_BOTH = 32'h480E_0000;
  localparam logic [31:0] EXP_NONE = 32'h490E_0000;
  logic        aclk;
  logic        aresetn;
  logic [11:0] awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [11:0] araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic [31:0] feature_word;
  logic        prot_ok;
  logic        vmid_hi;
  logic        stall_ok;
  int          n_fail;
  int          check_count;

  feature_id_regs #(
    .PROT_EXT_IMPL  (1'h1),
    .SECURE_STATE_PRESENT    (1'h1),
    .EXTRA_REC_IMPL (1'h1),
    .ENDIAN_IMPL    (2'h1),
    .VXOP_IMPL      (1'h1)
  ) i_feature_id_regs (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .feature_word(feature_word), .protect_fault_ok(prot_ok),
    .vm_id_hi_used(vmid_hi), .stall_allowed(stall_ok));

  // ========================================
  // Reporting
  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // ========================================
  // Bus tasks
  // A wait that runs out is a hang, so the run is closed at once.
  task automatic bus_write(input logic [11:0] a, input logic [31:0] v, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
    end while (bvalid !== 1'h1 && n < 40);
    bready <= 1'h0;
    check(32'(bresp), 32'(er));
    if (bvalid !== 1'h1) begin
      n_fail++;
      $display("Error at %0t: write timed out, got %h expected %h", $time, bvalid, 1'h1);
      complete_run();
    end
  endtask

  // Ready is raised one cycle late so that the held answer is exercised.
  task automatic bus_read(input logic [11:0] a, input logic [31:0] m,
                          input logic [31:0] e, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'h0;
      if (rvalid && !rready) rready <= 1'h1;
    end while (!(rvalid === 1'h1 && rready === 1'h1) && n < 40);
    rready <= 1'h0;
    check(rdata & m, e);
    check(32'(rresp), 32'(er));
    if (!(rvalid === 1'h1 && rready === 1'h1)) begin
      n_fail++;
      $display("Error at %0t: read timed out, got %h expected %h", $time, rvalid, 1'h1);
      complete_run();
    end
  endtask

  // ========================================
  // Scenarios
  task automatic test_reset_values;
    check(feature_word & HI_MASK, EXP_BOTH);
    check({29'h0, prot_ok, vmid_hi, stall_ok}, 32'h0000_0007);
  endtask

  task automatic test_read_word;
    bus_read(12'h000, HI_MASK, EXP_BOTH, RESP_OKAY);
    bus_read(12'h003, HI_MASK, EXP_BOTH, RESP_OKAY);
  endtask

  task automatic test_write_ignored;
    bus_write(12'h000, 32'hFFFF_FFFF, RESP_OKAY);
    bus_write(12'h008, 32'hFFFF_FFFF, RESP_OKAY);
    bus_read(12'h000, 32'hFFFF_FFFF, EXP_BOTH, RESP_OKAY);
    check(feature_word & HI_MASK, EXP_BOTH);
    // Only the lowest byte lane carries the stall-disable control.
    wstrb <= 4'he;
    bus_write(12'h004, 32'h0000_0001, RESP_OKAY);
    wstrb <= 4'hf;
    bus_read(12'h004, 32'h0000_0001, 32'h0000_0000, RESP_OKAY);
  endtask

  task automatic test_stall_disable;
    bus_write(12'h004, 32'h0000_0001, RESP_OKAY);
    bus_read(12'h004, 32'h0000_0001, 32'h0000_0001, RESP_OKAY);
    bus_read(12'h000, HI_MASK, EXP_NONE, RESP_OKAY);
    check({31'h0, stall_ok}, 32'h0000_0000);
    bus_read(12'h008, 32'h0000_035B, 32'h0000_015A, RESP_OKAY);
    bus_write(12'h004, 32'h0000_0000, RESP_OKAY);
    bus_read(12'h000, HI_MASK, EXP_BOTH, RESP_OKAY);
    check({31'h0, stall_ok}, 32'h0000_0001);
  endtask

  task automatic test_unmapped;
    bus_read(12'h010, 32'hFFFF_FFFF, 32'h0000_0000, RESP_SLVERR);
    bus_write(12'h010, 32'hFFFF_FFFF, RESP_SLVERR);
    bus_read(12'h000, HI_MASK, EXP_BOTH, RESP_OKAY);
  endtask

  task automatic test_midrun_reset;
    bus_write(12'h004, 32'h0000_0001, RESP_OKAY);
    @(posedge aclk);
    aresetn <= 1'h0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    bus_read(12'h004, 32'h0000_0001, 32'h0000_0000, RESP_OKAY);
    bus_read(12'h000, HI_MASK, EXP_BOTH, RESP_OKAY);
  endtask

  initial begin
    aclk = 1'h0;
    forever #4 aclk = ~aclk;
  end

  initial begin
    n_fail = 0;
    check_count = 0;
    aresetn = 1'h0;
    awaddr = 12'h000;
    awvalid = 1'h0;
    wdata = 32'h0000_0000;
    wstrb = 4'hf;
    wvalid = 1'h0;
    bready = 1'h0;
    araddr = 12'h000;
    arvalid = 1'h0;
    rready = 1'h0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (2) @(posedge aclk);
    test_reset_values();
    test_read_word();
    test_write_ignored();
    test_stall_disable();
    test_unmapped();
    test_midrun_reset();
    complete_run();
  end
endmodule
